/* File: bench/scmm_config_tb.sv */
/*
  Bench for the configuration block: resets, register map, loads, vectors.
  Assumes the shortened counts set on the instance below.
*/
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end

module scmm_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Por = 8;
  localparam int Win = 4;
  logic clk, rstn, porDetect, wdtTimeout, stopMode, romProtect;
  logic execExternal, romless, dmEnable, intAckValid, got;
  logic [2:0] intAckNum, stopSourceSel;
  logic [7:0] stopSource, rdData, fileAddr, watchdogMode;
  scmm_pkg::scmm_req_s regReq;
  scmm_pkg::scmm_mem_s memReq;
  scmm_pkg::scmm_cfg_s portCfg;
  logic coreReset, pcLoad, stopRecovered, keepPortDirections, rdValid;
  logic fileValid, fileWrite, progReadBlock, dataExternal;
  logic data_space_select_n, vectorValid;
  logic [15:0] pcValue, vectorAddr;
  int miscompares = 0;
  int checksDone = 0;
  int n;

  scmm_config #(.PorCycles(Por), .WdtWindowCycles(Win)) u_scmm_config (
    .clk, .rstn, .porDetect, .wdtTimeout, .stopMode, .stopSource, .regReq,
    .memReq, .romProtect, .execExternal, .romless, .dmEnable, .intAckValid,
    .intAckNum, .coreReset, .pcLoad, .pcValue, .stopRecovered,
    .keepPortDirections, .rdData, .rdValid, .fileAddr, .fileValid,
    .fileWrite, .progReadBlock, .dataExternal, .data_space_select_n,
    .vectorAddr, .vectorValid, .portCfg, .watchdogMode, .stopSourceSel
  );

  scmm_core_model u_scmm_core_model (
    .clk, .rdValid, .rdData, .fileValid, .fileAddr, .regReq
  );

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic waitPc();
    n = 0;
    while (pcLoad !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    `CHK({pcLoad, coreReset}, 2'b10)
    `CHK(pcValue, 16'h000C)
  endtask

  task automatic waitRec();
    n = 0;
    while (stopRecovered !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    stopMode = 1'b0;
    `CHK(n < 20, 1'b1)
    `CHK(coreReset, 1'b1)
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_scmm_core_model.put(scmm_pkg::MODE_DIRECT, a, 4'h0, 1'b1, d);
    u_scmm_core_model.done();
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    u_scmm_core_model.get(scmm_pkg::MODE_DIRECT, a, 4'h0);
    `CHK(u_scmm_core_model.gotRd, 1'b1)
    `CHK(u_scmm_core_model.gotData, e)
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #125000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    {rstn, porDetect, wdtTimeout, stopMode, romProtect} = 5'h00;
    {execExternal, romless, dmEnable, intAckValid} = 4'h0;
    {intAckNum, stopSource, memReq} = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    waitPc();
    `CHK(n inside {[Por - 1:Por + 4]}, 1'b1)
    // Pointer then watchdog mode back to back, inside the write window.
    u_scmm_core_model.put(scmm_pkg::MODE_DIRECT, 8'hFD, 4'h0, 1'b1, 8'h2F);
    u_scmm_core_model.put(scmm_pkg::MODE_DIRECT, 8'h0F, 4'h0, 1'b1, 8'h5A);
    u_scmm_core_model.done();
    `CHK(watchdogMode, 8'h5A)
    repeat (Win) @(negedge clk);
    wr(8'h0F, 8'h33);
    `CHK(watchdogMode, 8'h5A)
    rdChk(8'h0F, 8'h00);
    rdChk(8'hFD, 8'h2F);
    rdChk(8'h00, 8'hFE);
    rdChk(8'h05, 8'h00);
    // Struct order is route, port1, port0, drive port3..0, oscillator.
    wr(8'h00, 8'hA5);
    `CHK(portCfg, 8'hA9)
    rdChk(8'h00, 8'hA5);
    u_scmm_core_model.get(scmm_pkg::MODE_WORKING, 8'h00, 4'h3);
    `CHK(u_scmm_core_model.gotFile, 1'b1)
    `CHK(u_scmm_core_model.gotAddr, 8'h23)
    u_scmm_core_model.get(scmm_pkg::MODE_DIRECT, 8'hE5, 4'h0);
    `CHK({u_scmm_core_model.gotRd, u_scmm_core_model.gotFile}, 2'b00)
    u_scmm_core_model.get(scmm_pkg::MODE_INDIRECT, 8'hE5, 4'h0);
    `CHK({u_scmm_core_model.gotFile, u_scmm_core_model.gotAddr}, {1'b1, 8'hE5})
    wr(8'h37, 8'h00);
    `CHK({fileValid, fileWrite, fileAddr}, {2'b11, 8'h37})
    wr(8'hFD, 8'h21);
    rdChk(8'h00, 8'h00);
    wr(8'hFD, 8'h2F);
    wr(8'h0B, 8'h6C);
    `CHK(stopSourceSel, 3'h3)
    rdChk(8'h0B, 8'h00);
    // High level on source 3, long delay.
    stopSource = 8'h08;
    stopMode = 1'b1;
    waitRec();
    waitPc();
    `CHK(n inside {[Por - 1:Por + 4]}, 1'b1)
    `CHK(keepPortDirections, 1'b1)
    `CHK(watchdogMode, 8'h5A)
    `CHK(stopSourceSel, 3'h3)
    wr(8'hFD, 8'h2F);
    rdChk(8'h0B, 8'h80);
    // Low level on source 3, no delay.
    wr(8'h0B, 8'h0C);
    stopSource = 8'h00;
    stopMode = 1'b1;
    waitRec();
    waitPc();
    `CHK(n inside {[0:3]}, 1'b1)
    wr(8'hFD, 8'h2F);
    wr(8'h00, 8'h5A);
    `CHK(portCfg, 8'h56)
    wdtTimeout = 1'b1;
    @(negedge clk);
    wdtTimeout = 1'b0;
    waitPc();
    `CHK(keepPortDirections, 1'b0)
    `CHK(portCfg, 8'h7F)
    wr(8'hFD, 8'h2F);
    rdChk(8'h0B, 8'h80);
    porDetect = 1'b1;
    repeat (6) @(negedge clk);
    porDetect = 1'b0;
    waitPc();
    wr(8'hFD, 8'h2F);
    rdChk(8'h0B, 8'h00);
    for (int i = 0; i < 96; i++)
    begin
      memReq.kind = scmm_pkg::scmm_mem_e'(i % 3);
      memReq.addr = (i < 48) ? 16'h0FFF : 16'h1000;
      {romProtect, execExternal, romless, dmEnable} = 4'((i / 3) % 16);
      repeat (2) @(negedge clk);
      got = (i % 3 != 0) && !romless && i < 48 && romProtect && execExternal;
      `CHK(progReadBlock, got)
      `CHK(data_space_select_n, !(dmEnable && i % 3 == 2))
      `CHK(dataExternal, i % 3 == 2 && (romless || i >= 48))
    end
    for (int v = 0; v < 7; v++)
    begin
      @(negedge clk);
      intAckNum = 3'(v);
      intAckValid = 1'b1;
      got = 1'b0;
      repeat (3)
      begin
        @(negedge clk);
        intAckValid = 1'b0;
        if (vectorValid === 1'b1)
          got = 1'b1;
      end
      `CHK(got, v < 6)
      if (v < 6)
        `CHK(vectorAddr, 16'(2 * v))
    end
    finish_test();
  end
endmodule

/* File: bench/scmm_core_model.sv */
/*
  Core model: issues one register access per cycle and collects the answer.
  Assumes the block answers a read within three cycles of taking it.
*/
module scmm_core_model (
  input wire logic clk,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire logic fileValid,
  input wire logic [7:0] fileAddr,
  output scmm_pkg::scmm_req_s regReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gotRd;
  logic gotFile;
  logic [7:0] gotData;
  logic [7:0] gotAddr;

  initial regReq = '0;

  // Idle address and write data are scrambled so that sampling without a strobe shows up.
  task automatic idle();
    regReq.rd = 1'b0;
    regReq.wr = 1'b0;
    regReq.addr = ~regReq.addr;
    regReq.wdata = ~regReq.wdata;
  endtask

  task automatic put(input scmm_pkg::scmm_mode_e m, input logic [7:0] a,
    input logic [3:0] w, input logic wr, input logic [7:0] d);
    @(negedge clk);
    regReq = '{mode: m, addr: a, work: w, wr: wr, rd: !wr, wdata: d};
  endtask

  task automatic done();
    @(negedge clk);
    idle();
  endtask

  task automatic get(input scmm_pkg::scmm_mode_e m, input logic [7:0] a,
    input logic [3:0] w);
    gotRd = 1'b0;
    gotFile = 1'b0;
    put(m, a, w, 1'b0, 8'h00);
    repeat (3)
    begin
      done();
      if (rdValid === 1'b1)
      begin
        gotRd = 1'b1;
        gotData = rdData;
      end
      if (fileValid === 1'b1)
      begin
        gotFile = 1'b1;
        gotAddr = fileAddr;
      end
    end
  endtask
endmodule

/* File: rtl/scmm_config.sv */
/*
  System configuration block: reset sequencing from three sources, program
  counter start, interrupt vector addresses, program memory read protection,
  data space select, register pointer decoding and the expanded bank F
  configuration registers.
  Assumes the core presents at most one register access and one load request
  per cycle, and that pins porDetect and stopSource come from outside the clock.
*/
module scmm_config #(
  parameter int PorCycles = scmm_pkg::POR_CYCLES,
  parameter int WdtWindowCycles = scmm_pkg::WDT_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic porDetect,
  input wire logic wdtTimeout,
  input wire logic stopMode,
  input wire logic [7:0] stopSource,
  input wire scmm_pkg::scmm_req_s regReq,
  input wire scmm_pkg::scmm_mem_s memReq,
  input wire logic romProtect,
  input wire logic execExternal,
  input wire logic romless,
  input wire logic dmEnable,
  input wire logic intAckValid,
  input wire logic [2:0] intAckNum,
  output logic coreReset,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic stopRecovered,
  output logic keepPortDirections,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic [7:0] fileAddr,
  output logic fileValid,
  output logic fileWrite,
  output logic progReadBlock,
  output logic dataExternal,
  output logic data_space_select_n,
  output logic [15:0] vectorAddr,
  output logic vectorValid,
  output scmm_pkg::scmm_cfg_s portCfg,
  output logic [7:0] watchdogMode,
  output logic [2:0] stopSourceSel
);

  typedef struct packed {
    logic [2:0] porSync;
    logic porStable;
    logic [7:0] src0;
    logic [7:0] src1;
    logic [7:0] src2;
    logic [7:0] srcStable;
    logic [7:0] port_and_osc_config;
    logic [6:0] stop_recovery_control;
    logic stopFlag;
    logic [7:0] watchdog_mode_control;
    logic [7:0] group_pointer;
    logic [scmm_pkg::CNT_W-1:0] rstCnt;
    logic [scmm_pkg::WIN_W-1:0] winCnt;
    logic winOpen;
    logic coreRst;
    logic pcLoad;
    logic stopPulse;
    logic keepDir;
    logic [7:0] rdData;
    logic rdValid;
    logic [7:0] fileAddr;
    logic fileValid;
    logic fileWrite;
    logic progBlock;
    logic dataExt;
    logic dmN;
    logic [15:0] vecAddr;
    logic vecValid;
  } scmm_state_s;

  localparam logic [scmm_pkg::CNT_W-1:0] PorLoad = scmm_pkg::CNT_W'(PorCycles - 1);
  localparam logic [scmm_pkg::WIN_W-1:0] WinLoad = scmm_pkg::WIN_W'(WdtWindowCycles - 1);

  scmm_state_s s_q;
  scmm_state_s s_d;

  logic srcMatch;
  logic stopEvt;
  logic wdtEvt;
  logic [7:0] physAddr;
  logic blocked;
  logic inBankF;
  logic inOtherErf;
  logic hitPtr;
  logic progInternal;

  always_comb
  begin
    srcMatch = s_q.srcStable[s_q.stop_recovery_control[scmm_pkg::SR_SRC_HI:scmm_pkg::SR_SRC_LO]]
      == s_q.stop_recovery_control[scmm_pkg::SR_LEVEL_BIT]; // [RQ20] [RQ21]
    wdtEvt = wdtTimeout;
    stopEvt = stopMode && srcMatch && !s_q.coreRst;
    physAddr = (regReq.mode == scmm_pkg::MODE_WORKING) ?
      {s_q.group_pointer[7:4], regReq.work} : regReq.addr; // [RQ10] [RQ11]
    blocked = (regReq.mode == scmm_pkg::MODE_DIRECT) &&
      (physAddr[7:4] == scmm_pkg::BANKED_ROW); // [RQ12]
    inBankF = (physAddr[7:4] == scmm_pkg::ERF_ROW) &&
      (s_q.group_pointer[3:0] == scmm_pkg::ERF_BANK_F); // [RQ11]
    inOtherErf = (physAddr[7:4] == scmm_pkg::ERF_ROW) &&
      (s_q.group_pointer[3:0] != 4'h0) && !inBankF; // [RQ13]
    hitPtr = (physAddr == scmm_pkg::ADDR_GROUP_PTR);
    progInternal = !romless && (memReq.addr < scmm_pkg::INT_MEM_TOP); // [RQ8]

    s_d = s_q;
    s_d.porSync = {s_q.porSync[1:0], porDetect};
    if (s_q.porSync[1] == s_q.porSync[2])
    begin
      s_d.porStable = s_q.porSync[2];
    end
    s_d.src0 = stopSource;
    s_d.src1 = s_q.src0;
    s_d.src2 = s_q.src1;
    for (int i = 0; i < 8; i++)
    begin
      if (s_q.src1[i] == s_q.src2[i])
      begin
        s_d.srcStable[i] = s_q.src2[i];
      end
    end
    s_d.pcLoad = 1'b0;
    s_d.stopPulse = 1'b0;
    s_d.rdValid = 1'b0;
    s_d.fileValid = 1'b0;
    s_d.fileWrite = 1'b0;

    // A reset source wins over any register access in the same cycle.
    if (s_q.porStable) // [RQ1]
    begin
      s_d.port_and_osc_config = scmm_pkg::PORT_CFG_RST;
      s_d.stop_recovery_control = scmm_pkg::STOP_REC_RST;
      s_d.watchdog_mode_control = scmm_pkg::WDT_MODE_RST;
      s_d.group_pointer = scmm_pkg::GROUP_PTR_RST;
      s_d.stopFlag = 1'b0; // [RQ19]
      s_d.keepDir = 1'b0;
      s_d.coreRst = 1'b1;
      s_d.rstCnt = PorLoad; // [RQ3]
      s_d.winOpen = 1'b0;
    end
    else if (wdtEvt) // [RQ1]
    begin
      s_d.port_and_osc_config = scmm_pkg::PORT_CFG_RST;
      s_d.stop_recovery_control = scmm_pkg::STOP_REC_RST;
      s_d.watchdog_mode_control = scmm_pkg::WDT_MODE_RST;
      s_d.group_pointer = scmm_pkg::GROUP_PTR_RST;
      s_d.keepDir = 1'b0;
      s_d.coreRst = 1'b1;
      s_d.rstCnt = PorLoad;
      s_d.winOpen = 1'b0;
    end
    else if (stopEvt) // [RQ1]
    begin
      // Watchdog mode and stop recovery settings survive; port 2/3 keep theirs.
      s_d.port_and_osc_config = scmm_pkg::PORT_CFG_RST; // [RQ2]
      s_d.group_pointer = scmm_pkg::GROUP_PTR_RST;
      s_d.keepDir = 1'b1; // [RQ2]
      s_d.stopFlag = 1'b1; // [RQ19]
      s_d.stopPulse = 1'b1;
      s_d.coreRst = 1'b1;
      s_d.rstCnt = s_q.stop_recovery_control[scmm_pkg::SR_DELAY_BIT] ? PorLoad : '0; // [RQ25]
      s_d.winOpen = 1'b0;
    end
    else if (s_q.coreRst)
    begin
      if (s_q.rstCnt == '0)
      begin
        s_d.coreRst = 1'b0;
        s_d.pcLoad = 1'b1; // [RQ4]
        s_d.winOpen = 1'b1; // [RQ26]
        s_d.winCnt = WinLoad;
      end
      else
      begin
        s_d.rstCnt = s_q.rstCnt - 1'b1;
      end
    end
    else
    begin
      if (s_q.winOpen)
      begin
        if (s_q.winCnt == '0)
        begin
          s_d.winOpen = 1'b0; // [RQ23]
        end
        else
        begin
          s_d.winCnt = s_q.winCnt - 1'b1;
        end
      end
      if ((regReq.rd || regReq.wr) && !blocked)
      begin
        s_d.rdValid = regReq.rd;
        s_d.rdData = scmm_pkg::HIDDEN_READ;
        if (inBankF)
        begin
          case (physAddr[3:0])
            scmm_pkg::OFS_PORT_CFG:
            begin
              s_d.rdData = s_q.port_and_osc_config;
              if (regReq.wr)
              begin
                s_d.port_and_osc_config = regReq.wdata;
              end
            end
            scmm_pkg::OFS_STOP_REC:
            begin
              s_d.rdData = {s_q.stopFlag, 7'h00}; // [RQ22]
              if (regReq.wr)
              begin
                s_d.stop_recovery_control = regReq.wdata[6:0]; // [RQ22]
              end
            end
            scmm_pkg::OFS_WDT_MODE: // [RQ24]
            begin
              // Read data stays at the hidden value, so the contents never leak out.
              if (regReq.wr && s_q.winOpen) // [RQ23]
              begin
                s_d.watchdog_mode_control = regReq.wdata;
              end
            end
            default:
            begin
              s_d.rdData = scmm_pkg::HIDDEN_READ; // [RQ13]
            end
          endcase
        end
        else if (hitPtr)
        begin
          s_d.rdData = s_q.group_pointer;
          if (regReq.wr)
          begin
            s_d.group_pointer = regReq.wdata; // [RQ11]
          end
        end
        else if (!inOtherErf)
        begin
          s_d.rdValid = 1'b0;
          s_d.fileValid = 1'b1;
          s_d.fileWrite = regReq.wr;
          s_d.fileAddr = physAddr; // [RQ10]
        end
      end
    end

    s_d.progBlock = (memReq.kind != scmm_pkg::MEM_NONE) && progInternal &&
      romProtect && execExternal; // [RQ6] [RQ7]
    s_d.dataExt = (memReq.kind == scmm_pkg::MEM_DATA) && !progInternal; // [RQ8]
    s_d.dmN = !(dmEnable && (memReq.kind == scmm_pkg::MEM_DATA)); // [RQ9]
    s_d.vecValid = intAckValid && (intAckNum < scmm_pkg::VECTOR_COUNT);
    if (intAckValid)
    begin
      s_d.vecAddr = {12'h000, intAckNum, 1'b0}; // [RQ5]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.port_and_osc_config <= scmm_pkg::PORT_CFG_RST;
      s_q.coreRst <= 1'b1;
      s_q.rstCnt <= PorLoad;
      s_q.dmN <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign coreReset = s_q.coreRst;
  assign pcLoad = s_q.pcLoad;
  assign pcValue = scmm_pkg::PC_START;
  assign stopRecovered = s_q.stopPulse;
  assign keepPortDirections = s_q.keepDir;
  assign rdData = s_q.rdData;
  assign rdValid = s_q.rdValid;
  assign fileAddr = s_q.fileAddr;
  assign fileValid = s_q.fileValid;
  assign fileWrite = s_q.fileWrite;
  assign progReadBlock = s_q.progBlock;
  assign dataExternal = s_q.dataExt;
  assign data_space_select_n = s_q.dmN;
  assign vectorAddr = s_q.vecAddr;
  assign vectorValid = s_q.vecValid;
  assign portCfg.cmpRoute = s_q.port_and_osc_config[0]; // [RQ14]
  assign portCfg.port1PushPull = s_q.port_and_osc_config[1]; // [RQ15]
  assign portCfg.port0PushPull = s_q.port_and_osc_config[2]; // [RQ16]
  assign portCfg.portStdDrive = s_q.port_and_osc_config[6:3]; // [RQ17]
  assign portCfg.oscStdDrive = s_q.port_and_osc_config[7]; // [RQ18]
  assign watchdogMode = s_q.watchdog_mode_control;
  assign stopSourceSel = s_q.stop_recovery_control[scmm_pkg::SR_SRC_HI:scmm_pkg::SR_SRC_LO];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence stopShort;
    stopEvt && !s_q.stop_recovery_control[scmm_pkg::SR_DELAY_BIT] && !s_q.porStable && !wdtEvt;
  endsequence

  sequence shortRelease;
    s_q.coreRst ##1 (!s_q.coreRst && s_q.pcLoad);
  endsequence

  a_por_clears_flag: // [RQ19]
    assert property (s_q.porStable |=> s_q.coreRst && !s_q.stopFlag)
      else $error("power-on did not clear recovery flag");
  a_stop_keeps_regs: // [RQ2]
    assert property (stopEvt && !s_q.porStable && !wdtEvt |=>
      $stable(s_q.watchdog_mode_control) && $stable(s_q.stop_recovery_control) && s_q.keepDir)
      else $error("stop recovery disturbed kept registers");
  a_stop_short_delay: // [RQ25]
    assert property (stopShort |=> shortRelease)
      else $error("recovery without delay did not release in one cycle");
  a_release_loads_pc: // [RQ4]
    assert property ($fell(s_q.coreRst) |-> s_q.pcLoad && pcValue == scmm_pkg::PC_START)
      else $error("release without program counter load");
  a_direct_bank_blocked: // [RQ12]
    assert property (!s_q.coreRst && blocked && !s_q.porStable && !wdtEvt && !stopEvt |=>
      !s_q.fileValid && !s_q.rdValid)
      else $error("direct access reached bank E");
  a_wdt_write_locked: // [RQ23]
    assert property (!s_q.winOpen && !s_q.coreRst && !s_q.porStable && !wdtEvt |=>
      $stable(s_q.watchdog_mode_control))
      else $error("watchdog mode changed after window");
  a_wdt_hidden_read: // [RQ24]
    assert property (!s_q.coreRst && regReq.rd && inBankF && !blocked &&
      physAddr[3:0] == scmm_pkg::OFS_WDT_MODE && !s_q.porStable && !wdtEvt && !stopEvt |=>
      s_q.rdValid && s_q.rdData == scmm_pkg::HIDDEN_READ)
      else $error("watchdog mode read returned contents");
  a_protect_block: // [RQ6]
    assert property (romProtect && execExternal && memReq.kind == scmm_pkg::MEM_PROGRAM &&
      !romless && memReq.addr < scmm_pkg::INT_MEM_TOP |=> s_q.progBlock)
      else $error("protected program read not blocked");
  a_dm_select: // [RQ9]
    assert property (dmEnable && memReq.kind == scmm_pkg::MEM_PROGRAM |=> s_q.dmN)
      else $error("data select active on program load");
  a_working_map: // [RQ10]
    assert property (s_q.fileValid && $past(regReq.mode) == scmm_pkg::MODE_WORKING |->
      s_q.fileAddr == {$past(s_q.group_pointer[7:4]), $past(regReq.work)})
      else $error("working register address mapped wrongly");

endmodule

/* File: rtl/scmm_pkg.sv */
/*
  Package for the system configuration block: register addresses, reset values,
  field positions, timing constants and the carrier types shared by the block.
  Assumes a single 40 MHz system clock and a core that issues one register
  access per cycle at most.
*/
// Overview of operation
// [RQ1] Reset comes only from power-on detector, watchdog timeout or stop recovery.
// [RQ2] Stop recovery keeps watchdog mode, stop recovery and port 2/3 direction setup.
// [RQ3] Power-on reset holds the core in reset for about five milliseconds.
// [RQ4] After any reset the program counter loads address 000C.
// [RQ5] The lowest twelve bytes hold six 16-bit interrupt vectors, not user code.
// [RQ6] Protected part running externally cannot read internal program memory by loads.
// [RQ7] Protected part running internally may still read internal program memory.
// [RQ8] Internal mode puts external data from 4096 up; external-only mode uses all 64 KB.
// [RQ9] Data space select stays high for program loads, goes low for data loads.
// [RQ10] Working-register addressing uses 16 groups of 16, chosen by the pointer.
// [RQ11] Pointer low nibble picks expanded group, high nibble picks working group.
// [RQ12] Registers E0 to EF are unreachable through direct 8-bit addressing.
// [RQ13] Expanded bank F holds only the three configuration registers; rest reserved.
// [RQ14] Config bit 0 routes comparator outputs to port 3 pins 4 and 7.
// [RQ15] Config bit 1 selects port 1 open-drain at zero, push-pull at one.
// [RQ16] Config bit 2 selects port 0 open-drain at zero, push-pull at one.
// [RQ17] Config bits 3 to 6 pick reduced or standard drive for ports 0 to 3.
// [RQ18] Config bit 7 picks low-noise or standard oscillator drive, clock ratio unchanged.
// [RQ19] Stop recovery flag bit 7 is read-only, set by recovery, cleared by power-on.
// [RQ20] Stop recovery bit 6 picks source level, bit 5 the post-recovery delay.
// [RQ21] Stop recovery bits 2 to 4 select the recovery source.
// [RQ22] Stop recovery register sits at 0B of bank F; bits below 7 write-only.
// [RQ23] Watchdog mode register takes writes only during a window after reset.
// [RQ24] Watchdog mode register sits at 0F of bank F and never reads back.
// [RQ25] Stop recovery bit 5 set enables the power-on delay after recovery.
// [RQ26] The watchdog write window length is a parameter counted in clock cycles.
package scmm_pkg;

  localparam int CLK_KHZ = 40000;
  localparam int POR_TIME_MS = 5;
  localparam int POR_CYCLES = POR_TIME_MS * CLK_KHZ;
  localparam int WDT_WINDOW_CYCLES = 64;
  localparam int CNT_W = 18;
  localparam int WIN_W = 16;

  localparam logic [7:0] ADDR_GROUP_PTR = 8'hFD;
  localparam logic [3:0] ERF_BANK_F = 4'hF;
  localparam logic [3:0] ERF_ROW = 4'h0;
  localparam logic [3:0] BANKED_ROW = 4'hE;
  localparam logic [3:0] OFS_PORT_CFG = 4'h0;
  localparam logic [3:0] OFS_STOP_REC = 4'hB;
  localparam logic [3:0] OFS_WDT_MODE = 4'hF;

  localparam logic [7:0] PORT_CFG_RST = 8'hFE;
  localparam logic [6:0] STOP_REC_RST = 7'h00;
  localparam logic [7:0] WDT_MODE_RST = 8'h00;
  localparam logic [7:0] GROUP_PTR_RST = 8'h00;
  localparam logic [7:0] HIDDEN_READ = 8'h00;

  localparam int SR_FLAG_BIT = 7;
  localparam int SR_LEVEL_BIT = 6;
  localparam int SR_DELAY_BIT = 5;
  localparam int SR_SRC_LO = 2;
  localparam int SR_SRC_HI = 4;

  localparam logic [15:0] PC_START = 16'h000C;
  localparam logic [15:0] INT_MEM_TOP = 16'h1000;
  localparam logic [2:0] VECTOR_COUNT = 3'h6;

  typedef enum logic [1:0] {MODE_DIRECT, MODE_WORKING, MODE_INDIRECT} scmm_mode_e;
  typedef enum logic [1:0] {MEM_NONE, MEM_PROGRAM, MEM_DATA} scmm_mem_e;

  typedef struct packed {
    scmm_mode_e mode;
    logic [7:0] addr;
    logic [3:0] work;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } scmm_req_s;

  typedef struct packed {
    scmm_mem_e kind;
    logic [15:0] addr;
  } scmm_mem_s;

  typedef struct packed {
    logic cmpRoute;
    logic port1PushPull;
    logic port0PushPull;
    logic [3:0] portStdDrive;
    logic oscStdDrive;
  } scmm_cfg_s;

endpackage
